// ===== src/gpio_pkg.sv
// Package: register map, field masks and pin bundles for the GPIO port block
package gpio_pkg;

	// Register byte offsets
	localparam logic [7:0] off_pull_edge_polarity = 8'h00;
	localparam logic [7:0] off_pin_irq_enable = 8'h04;
	localparam logic [7:0] off_pin_irq_flags = 8'h08;
	localparam logic [7:0] off_pull_enable = 8'h0c;
	localparam logic [7:0] off_second_port_data = 8'h10;
	localparam logic [7:0] off_second_port_pin_input = 8'h14;
	localparam logic [7:0] off_second_port_direction = 8'h18;
	localparam logic [7:0] off_second_port_drive_strength = 8'h1c;

	// Implemented bits of the second port: 7-6 and 1-0
	localparam logic [7:0] second_port_mask = 8'hc3;
	localparam logic [7:0] ctrl_reset_value = 8'h00;
	localparam int addr_width = 8;

	typedef struct packed {
		logic [7:0] out;
		logic [7:0] out_en_n;
		logic [7:0] reduced_drive;
		logic [7:0] pull_on;
		logic [7:0] pull_down;
	} pad_ctrl_t;

	typedef struct packed {
		logic [addr_width-1:0] addr;
		logic write;
		logic [31:0] wdata;
	} bus_req_t;

endpackage : gpio_pkg

// ===== src/pin_sync_edge.sv
// Two-flop pin synchroniser with polarity-selectable edge detector
`timescale 1ns/1ps
module pin_sync_edge
	import gpio_pkg::*;
#(
	parameter int width = 8
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Pins and edge select
	input wire logic [width-1:0] pin_async,
	input wire logic [width-1:0] rising_sel,
	// Results
	output logic [width-1:0] pin_sync,
	output logic [width-1:0] edge_hit
);

	logic [width-1:0] meta_q;
	logic [width-1:0] sync_q;
	logic [width-1:0] prev_q;

	// R16 sync before edges
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			meta_q <= '0;
			sync_q <= '0;
			prev_q <= '0;
		end
		else
		begin
			meta_q <= pin_async;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	assign pin_sync = sync_q;

	// R01 edge polarity choice
	assign edge_hit = (rising_sel & sync_q & ~prev_q) |
		(~rising_sel & ~sync_q & prev_q);

endmodule : pin_sync_edge

// ===== src/gpio_port.sv
// GPIO port: pin-interrupt port and second data port behind an APB slave
//
// Notes on behaviour
// R01 - Polarity 1: pull-down and rising edge; 0: pull-up and falling edge.
// R02 - Polarity sets pull direction only if pulled; always sets edge.
// R03 - Flag sets after an active edge on its pin, bits 7 to 0.
// R04 - Writing 1 clears a flag; writing 0 leaves it.
// R05 - Interrupt requested when any flag and its enable are both set.
// R06 - Enable 0 masks the request; the flag still sets.
// R07 - Pin interrupts work whether pin is input or output.
// R08 - Second port has bits 7-6, 1-0; outputs drive data bits.
// R09 - Data read gives register where output, pin state where input.
// R10 - Input register read always gives buffered pin state.
// R11 - Writes to the input register change nothing.
// R12 - Direction 1 makes the pin output, 0 makes it input.
// R13 - Reduced-drive 1 signals reduced strength, 0 full strength.
// R14 - Reduced-drive has no effect on an input pin.
// R15 - Pull active only when enabled, and never on an output.
// R16 - Pins synchronised first; set beats clear in same cycle.
// R17 - Reset clears controls and flags: inputs, interrupts masked.
`timescale 1ns/1ps
module gpio_port
	import gpio_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [addr_width-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Interrupt port pins
	input wire logic [7:0] irq_port_pin_in,
	output logic [7:0] irq_port_pull_on,
	output logic [7:0] irq_port_pull_down,
	// Second port pins
	input wire logic [7:0] second_port_pin_in,
	output pad_ctrl_t second_port_pad,
	// Interrupt request
	output logic irq
);

	////////////////////////////////////////////////////////////////////////
	// Registers

	logic [7:0] polarity_q;
	logic [7:0] irq_enable_q;
	logic [7:0] irq_flags_q;
	logic [7:0] irq_flags_d;
	logic [7:0] pull_enable_q;
	logic [7:0] data_q;
	logic [7:0] direction_q;
	logic [7:0] drive_q;
	logic [7:0] irq_pin_sync;
	logic [7:0] irq_edges;
	logic [7:0] sp_pin_sync;
	logic [7:0] zero_sel;
	bus_req_t req;
	logic wr_go;
	logic rd_go;
	logic [31:0] rdata_d;
	logic known_d;

	assign zero_sel = 8'h00;

	function automatic logic wr_hit(input bus_req_t r,
		input logic [addr_width-1:0] off);
		wr_hit = r.write && (r.addr == off);
	endfunction : wr_hit

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	pin_sync_edge #(
		.width(8)
	) u_irq_pins (
		.clk(clk),
		.reset_n(reset_n),
		.pin_async(irq_port_pin_in),
		.rising_sel(polarity_q),
		.pin_sync(irq_pin_sync),
		.edge_hit(irq_edges)
	);

	// Edge output unused: second port has no interrupt logic here
	pin_sync_edge #(
		.width(8)
	) u_second_pins (
		.clk(clk),
		.reset_n(reset_n),
		.pin_async(second_port_pin_in),
		.rising_sel(zero_sel),
		.pin_sync(sp_pin_sync),
		.edge_hit()
	);

	////////////////////////////////////////////////////////////////////////
	// APB decode

	assign req = '{addr: paddr, write: pwrite, wdata: pwdata};
	// Zero-wait slave: access completes in the first access cycle
	assign wr_go = psel && penable && pwrite;
	assign rd_go = psel && !penable && !pwrite;

	always_comb
	begin
		rdata_d = 32'h0000_0000;
		known_d = 1'b1;
		case (paddr)
			off_pull_edge_polarity: rdata_d[7:0] = polarity_q;
			off_pin_irq_enable: rdata_d[7:0] = irq_enable_q;
			off_pin_irq_flags: rdata_d[7:0] = irq_flags_q;
			off_pull_enable: rdata_d[7:0] = pull_enable_q;
			// R09 data read source
			off_second_port_data: rdata_d[7:0] = second_port_mask &
				((direction_q & data_q) | (~direction_q & sp_pin_sync));
			// R10 always pin state
			off_second_port_pin_input:
				rdata_d[7:0] = second_port_mask & sp_pin_sync;
			off_second_port_direction: rdata_d[7:0] = direction_q;
			off_second_port_drive_strength: rdata_d[7:0] = drive_q;
			default: known_d = 1'b0;
		endcase
	end

	// Read data latched in setup so it stands through the access phase
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			prdata <= 32'h0000_0000;
		else if (rd_go)
			prdata <= rdata_d;
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !known_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Control registers

	// R17 reset masks interrupts
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			polarity_q <= ctrl_reset_value;
			irq_enable_q <= ctrl_reset_value;
			pull_enable_q <= ctrl_reset_value;
		end
		else if (wr_go)
		begin
			if (wr_hit(req, off_pull_edge_polarity))
				polarity_q <= req.wdata[7:0];
			if (wr_hit(req, off_pin_irq_enable))
				irq_enable_q <= req.wdata[7:0];
			if (wr_hit(req, off_pull_enable))
				pull_enable_q <= req.wdata[7:0];
		end
	end

	// R11 input register not writable
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			data_q <= ctrl_reset_value;
			direction_q <= ctrl_reset_value;
			drive_q <= ctrl_reset_value;
		end
		else if (wr_go)
		begin
			if (wr_hit(req, off_second_port_data))
				data_q <= req.wdata[7:0] & second_port_mask;
			if (wr_hit(req, off_second_port_direction))
				direction_q <= req.wdata[7:0] & second_port_mask;
			if (wr_hit(req, off_second_port_drive_strength))
				drive_q <= req.wdata[7:0] & second_port_mask;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Interrupt flags

	// R03 set on edge
	// R04 write one clears
	// R16 set beats clear
	always_comb
	begin
		irq_flags_d = irq_flags_q;
		if (wr_go && wr_hit(req, off_pin_irq_flags))
			irq_flags_d = irq_flags_d & ~req.wdata[7:0];
		// R07 edges regardless of direction
		irq_flags_d = irq_flags_d | irq_edges;
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			irq_flags_q <= ctrl_reset_value;
		else
			irq_flags_q <= irq_flags_d;
	end

	// R05 request from enabled flags
	// R06 enable masks request
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			irq <= 1'b0;
		else
			irq <= |(irq_flags_d & irq_enable_q);
	end

	////////////////////////////////////////////////////////////////////////
	// Pad controls

	// R02 pull direction only if pulled
	// R15 pull enable gating
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			irq_port_pull_on <= 8'h00;
			irq_port_pull_down <= 8'h00;
		end
		else
		begin
			irq_port_pull_on <= pull_enable_q;
			// R01 polarity picks pull-down
			irq_port_pull_down <= pull_enable_q & polarity_q;
		end
	end

	// R08 outputs drive data
	// R12 direction sets enable
	// R13 reduced drive signal
	// R14 ignored on inputs
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			second_port_pad <= '{out: 8'h00, out_en_n: 8'hff,
				reduced_drive: 8'h00, pull_on: 8'h00, pull_down: 8'h00};
		else
		begin
			second_port_pad.out <= data_q & second_port_mask;
			second_port_pad.out_en_n <= ~(direction_q & second_port_mask);
			second_port_pad.reduced_drive <= drive_q & direction_q;
			second_port_pad.pull_on <= 8'h00;
			second_port_pad.pull_down <= 8'h00;
		end
	end

endmodule : gpio_port

// ===== testbench/gpio_port_checker.sv
// Checker: bus timing and pad relations of the GPIO port
`timescale 1ns/1ps
module gpio_port_checker
	import gpio_pkg::*;
(
	// Clock, reset, bus
	input wire logic clk,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [addr_width-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Pins
	input wire logic [7:0] irq_port_pin_in,
	input wire logic [7:0] irq_port_pull_on,
	input wire logic [7:0] irq_port_pull_down,
	input wire logic [7:0] second_port_pin_in,
	input wire pad_ctrl_t second_port_pad,
	input wire logic irq
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	// Synchronisers must have run three edges before the read counts
	sequence pin_read_s;
		$stable(second_port_pin_in)[*3] ##0 $past(reset_n, 3) && psel
			&& !penable && !pwrite && paddr == off_second_port_pin_input;
	endsequence
	rdy_after_setup_a: assert property (psel && !penable |=> pready)
		else $error("ready late");
	rdy_pulse_a: assert property (pready |=> !pready)
		else $error("ready too long");
	err_with_rdy_a: assert property (pslverr |-> pready && psel && penable)
		else $error("stray error");
	unused_bits_a: assert property (second_port_pad.out[5:2] == 4'h0 &&
		&second_port_pad.out_en_n[5:2]) else $error("unused pin driven");
	drive_out_a: assert property (
		(second_port_pad.reduced_drive & second_port_pad.out_en_n) == 8'h00)
		else $error("reduced drive on input");
	pull_dir_a: assert property (
		(irq_port_pull_down & ~irq_port_pull_on) == 8'h00)
		else $error("pull without enable");
	reset_state_a: assert property ($rose(reset_n) |-> !irq &&
		second_port_pad.out_en_n == 8'hff) else $error("reset state");
	pin_read_a: assert property (pin_read_s |=> prdata[7:0] ==
		($past(second_port_pin_in) & second_port_mask))
		else $error("pin input read");
	// Flag clear drops irq one edge after the write, enable clear two
	irq_fall_a: assert property (
		$fell(irq) |-> $past(psel && penable && pwrite) ||
		$past(psel && penable && pwrite, 2))
		else $error("irq fell without write");
endmodule : gpio_port_checker

bind gpio_port gpio_port_checker gpio_port_checker_i (.clk, .reset_n,
	.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
	.irq_port_pin_in, .irq_port_pull_on, .irq_port_pull_down,
	.second_port_pin_in, .second_port_pad, .irq);

// ===== testbench/pin_pad_model.sv
// Pad model: pin levels from pad controls, pulls and outside drivers
`timescale 1ns/1ps
module pin_pad_model
	import gpio_pkg::*;
(
	// Clock
	input wire logic clk,
	// Pad controls
	input wire pad_ctrl_t second_port_pad,
	input wire logic [7:0] irq_port_pull_on,
	input wire logic [7:0] irq_port_pull_down,
	// Outside drivers
	input wire logic [7:0] irq_ext,
	input wire logic [7:0] irq_ext_en,
	input wire logic [7:0] sp_ext,
	// Pin levels
	output logic [7:0] irq_port_pin_in,
	output logic [7:0] second_port_pin_in
);
	logic [7:0] flt;
	// Undriven, unpulled pins wander, never hold a value
	assign flt = {4{clk, ~clk}};
	assign irq_port_pin_in = (irq_ext_en & irq_ext) | (~irq_ext_en &
		((irq_port_pull_on & ~irq_port_pull_down) | (~irq_port_pull_on & flt)));
	assign second_port_pin_in = (~second_port_pad.out_en_n &
		second_port_pad.out) | (second_port_pad.out_en_n & sp_ext);
endmodule : pin_pad_model

// ===== testbench/test_gpio_port.sv
// Testbench: register and pin checks of the GPIO port
`timescale 1ns/1ps
module test_gpio_port
	import gpio_pkg::*;
;
	logic clk, reset_n, psel, penable, pwrite, pready, pslverr, irq, bad;
	logic [7:0] paddr, q, irq_port_pin_in, second_port_pin_in;
	logic [7:0] irq_port_pull_on, irq_port_pull_down, irq_ext, irq_ext_en;
	logic [7:0] sp_ext;
	logic [31:0] pwdata, prdata;
	pad_ctrl_t second_port_pad;
	int err_count, checks_done;

	gpio_port gpio_port_i (.clk, .reset_n, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .irq_port_pin_in,
		.irq_port_pull_on, .irq_port_pull_down, .second_port_pin_in,
		.second_port_pad, .irq);
	pin_pad_model pin_pad_model_i (.clk, .second_port_pad, .irq_port_pull_on,
		.irq_port_pull_down, .irq_ext, .irq_ext_en, .sp_ext,
		.irq_port_pin_in, .second_port_pin_in);

	////////////////////////////////////////////////////////////////////////
	task automatic close_out();
		if (err_count == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : close_out

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			err_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d);
		@(posedge clk);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= {24'h0, d};
		@(posedge clk);
		penable <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		q = prdata[7:0];
		bad = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		xfer(a, 1'b0, 8'h00);
		chk(q, exp);
	endtask : rd

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	initial
	begin
		#200000;
		err_count++;
		close_out();
	end

	initial
	begin
		{reset_n, psel, penable, pwrite, paddr, pwdata} = '0;
		{irq_ext, irq_ext_en, sp_ext} = 24'h00ff5a;
		{err_count, checks_done} = '0;
		cyc(8);
		reset_n <= 1'b1;
		for (int i = 0; i < 8; i++)
			if (i != 4 && i != 5) rd(8'(4 * i), 8'h00);
		rd(off_second_port_data, 8'h42);
		rd(off_second_port_pin_input, 8'h42);
		rd(8'h20, 8'h00);
		chk({7'h0, bad}, 8'h01);
		xfer(off_second_port_direction, 1'b1, 8'hff);
		rd(off_second_port_direction, 8'hc3);
		xfer(off_second_port_data, 1'b1, 8'h81);
		xfer(off_second_port_pin_input, 1'b1, 8'hff);
		rd(off_second_port_data, 8'h81);
		rd(off_second_port_pin_input, 8'h81);
		chk(second_port_pad.out_en_n, 8'h3c);
		chk(second_port_pad.out, 8'h81);
		xfer(off_second_port_drive_strength, 1'b1, 8'hff);
		cyc(2);
		chk(second_port_pad.reduced_drive, 8'hc3);
		xfer(off_second_port_direction, 1'b1, 8'h00);
		cyc(2);
		chk(second_port_pad.reduced_drive, 8'h00);
		xfer(off_pull_edge_polarity, 1'b1, 8'h0f);
		irq_ext <= 8'hff;
		cyc(6);
		rd(off_pin_irq_flags, 8'h0f);
		irq_ext <= 8'h00;
		cyc(6);
		rd(off_pin_irq_flags, 8'hff);
		chk({7'h0, irq}, 8'h00);
		xfer(off_pin_irq_flags, 1'b1, 8'h05);
		rd(off_pin_irq_flags, 8'hfa);
		xfer(off_pin_irq_enable, 1'b1, 8'h02);
		cyc(2);
		chk({7'h0, irq}, 8'h01);
		xfer(off_pin_irq_flags, 1'b1, 8'h02);
		cyc(2);
		chk({7'h0, irq}, 8'h00);
		// Edge lands on the clearing write's edge: the flag must survive
		irq_ext <= 8'h02;
		xfer(off_pin_irq_flags, 1'b1, 8'h02);
		rd(off_pin_irq_flags, 8'hfa);
		chk({7'h0, irq}, 8'h01);
		xfer(off_pull_enable, 1'b1, 8'hff);
		// Release only once the pulls are on, so no pin floats
		cyc(1);
		irq_ext_en <= 8'h00;
		cyc(5);
		chk(irq_port_pull_down, 8'h0f);
		chk(irq_port_pin_in, 8'hf0);
		close_out();
	end
endmodule : test_gpio_port
